/* rwd_watchdog.sv */
// module: supervision timer with an AXI4-Lite register slave
`timescale 1ns/10ps

// Notes on behaviour
// - enable bit starts and stops the watchdog
// - supply loss clears enable; stays cleared afterwards
// - expiry sets timeout flag and drives output
// - no restart until flag written back zero
// - start delay waits 64 s before counting
// - pulse width 122 us or 125 ms
// - period select picks eight time-out lengths
// - fast event edge clears count when enabled, in the count phase only
module rwd_watchdog
   import rwd_pkg::*;
#(
   parameter int TICK_DIV_INC = TICK_INC, // phase step per clock for the crystal tick
   parameter int DELAY_LEN = DELAY_TICKS // start delay in ticks, shorten for simulation
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic vccPresent, // main supply good, asynchronous
   input wire logic fastEventInput, // fast event pin, asynchronous
   output logic timeoutOutputPin, // high while the time-out pulse runs
   output logic irq // level interrupt
);
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // gray-coded timer states along idle -> delay -> count -> expired
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_COUNT = 2'b11,
      ST_EXPIRED = 2'b10
   } rwd_state_t;

   // period in crystal ticks per period_select code, raw time base only
   function automatic logic [CNT_W-1:0] periodTicks(input logic [2:0] sel);
      case (sel)
         3'h0: periodTicks = 22'(32); // 977 us
         3'h1: periodTicks = 22'(512); // 15.6 ms
         3'h2: periodTicks = 22'(2048); // 62.5 ms
         3'h3: periodTicks = 22'(4096); // 125 ms
         3'h4: periodTicks = 22'(32768); // 1 s
         3'h5: periodTicks = 22'(524288); // 16 s
         3'h6: periodTicks = 22'(1048576); // 32 s
         default: periodTicks = 22'(2097152); // 64 s
      endcase
   endfunction : periodTicks

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [ACC_W-1:0] phaseAcc; // crystal tick phase accumulator
   logic tickCarry; // carry out of accumulator
   logic tick; // one-cycle 32.768 kHz enable
   logic [2:0] vccSync; // three-stage supply synchroniser
   logic vccGood; // filtered supply state
   logic [2:0] evSync; // three-stage event synchroniser
   logic evLevel; // filtered event level
   logic [7:0] wdCtrl; // watchdog_control
   logic [1:0] irqStat; // sticky status
   logic [1:0] irqMask; // mask
   logic eventKickEnable; // event_pin_kick_enable
   rwd_state_t state;
   rwd_state_t next_state;
   logic [CNT_W-1:0] count; // tick counter for delay and period
   logic [CNT_W-1:0] pulseCnt; // remaining pulse ticks
   logic awHeld, wHeld; // address or data captured
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   // ----------------------------------------------------------------
   // crystal tick divider
   // ----------------------------------------------------------------
   // accumulator keeps the long-term rate exact at 200 MHz
   wire [ACC_W:0] phaseSum = {1'b0, phaseAcc} + {1'b0, 32'(TICK_DIV_INC)}; // sum with carry out
   assign tickCarry = phaseSum[ACC_W];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phaseAcc <= '0;
         tick <= 1'b0;
      end else begin
         phaseAcc <= phaseAcc + 32'(TICK_DIV_INC);
         tick <= tickCarry;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // a change counts only once stages two and three agree
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         vccSync <= 3'h0;
         evSync <= 3'h0;
         vccGood <= 1'b0;
         evLevel <= 1'b0;
      end else begin
         vccSync <= {vccSync[1:0], vccPresent};
         evSync <= {evSync[1:0], fastEventInput};
         if (vccSync[2] == vccSync[1]) vccGood <= vccSync[2];
         if (evSync[2] == evSync[1]) evLevel <= evSync[2];
      end
   end
   logic evLevelQ; // previous filtered event level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) evLevelQ <= 1'b0;
      else evLevelQ <= evLevel;
   end
   wire evEdge = evLevel ^ evLevelQ; // either direction
   wire kick = eventKickEnable & evEdge;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
   wire wrCtrl = doWrite & (awAddr == ADDR_WDCTRL) & wStrb[0];
   wire wrStat = doWrite & (awAddr == ADDR_IRQSTAT) & wStrb[0];
   wire wrMask = doWrite & (awAddr == ADDR_IRQMASK) & wStrb[0];
   wire wrAux = doWrite & (awAddr == ADDR_AUX) & wStrb[0];
   wire wrMapped = (awAddr == ADDR_WDCTRL) | (awAddr == ADDR_IRQSTAT) |
                   (awAddr == ADDR_IRQMASK) | (awAddr == ADDR_AUX);
   wire vccLoss = ~vccGood & wdCtrl[BIT_ENABLE];
   wire expire = (state == ST_COUNT) & tick & (count >= periodTicks(wdCtrl[2:0]) - 22'(1));
   wire [CNT_W-1:0] pulseLen = wdCtrl[BIT_PULSE] ? 22'(PULSE_LONG_TICKS) :
                                                  22'(PULSE_SHORT_TICKS);

   // ----------------------------------------------------------------
   // watchdog_control register
   // ----------------------------------------------------------------
   // hardware set of the flag and clear of the enable win over software
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wdCtrl <= WDCTRL_RESET;
      end else begin
         if (wrCtrl) wdCtrl <= wData[7:0];
         if (expire) wdCtrl[BIT_FLAG] <= 1'b1;
         if (~vccGood) wdCtrl[BIT_ENABLE] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // timer state machine
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            // wait for enable with the flag clear
            if (wdCtrl[BIT_ENABLE] & ~wdCtrl[BIT_FLAG])
               next_state = wdCtrl[BIT_DELAY] ? ST_DELAY : ST_COUNT;
         end
         ST_DELAY: begin
            if (~wdCtrl[BIT_ENABLE]) next_state = ST_IDLE;
            else if (tick & (count >= 22'(DELAY_LEN) - 22'(1))) next_state = ST_COUNT;
         end
         ST_COUNT: begin
            if (~wdCtrl[BIT_ENABLE]) next_state = ST_IDLE;
            else if (expire) next_state = ST_EXPIRED;
         end
         ST_EXPIRED: begin
            // only a write of zero to the flag restarts
            if (~wdCtrl[BIT_FLAG]) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // counter: zero when idle or expired, on a phase change or on a kick while counting
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         if (next_state != state || state == ST_IDLE || state == ST_EXPIRED)
            count <= '0;
         else if (kick && state == ST_COUNT) count <= '0;
         else if (tick) count <= count + 22'(1);
      end
   end

   // ----------------------------------------------------------------
   // output pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulseCnt <= '0;
         timeoutOutputPin <= 1'b0;
      end else if (expire) begin
         pulseCnt <= pulseLen;
         timeoutOutputPin <= 1'b1;
      end else if (tick && pulseCnt != '0) begin
         pulseCnt <= pulseCnt - 22'(1);
         if (pulseCnt == 22'(1)) timeoutOutputPin <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, mask and aux
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqStat <= IRQ_RESET;
         irqMask <= IRQ_RESET;
         eventKickEnable <= 1'b0;
         irq <= 1'b0;
      end else begin
         // a new event in the clear cycle survives
         irqStat[IRQ_TIMEOUT] <= expire | (irqStat[IRQ_TIMEOUT] & ~(wrStat & wData[IRQ_TIMEOUT]));
         irqStat[IRQ_VCCLOSS] <= vccLoss | (irqStat[IRQ_VCCLOSS] & ~(wrStat & wData[IRQ_VCCLOSS]));
         if (wrMask) irqMask <= wData[1:0];
         if (wrAux) eventKickEnable <= wData[0];
         irq <= |(irqStat & irqMask);
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   // one write at a time; address and data accepted in either order
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   wire [7:0] rdAddr = {s_axi_araddr[7:2], 2'b00};
   wire rdMapped = (rdAddr == ADDR_WDCTRL) | (rdAddr == ADDR_IRQSTAT) |
                   (rdAddr == ADDR_IRQMASK) | (rdAddr == ADDR_AUX);
   wire [31:0] rdMux = (rdAddr == ADDR_WDCTRL) ? {24'h0, wdCtrl} :
                       (rdAddr == ADDR_IRQSTAT) ? {30'h0, irqStat} :
                       (rdAddr == ADDR_IRQMASK) ? {30'h0, irqMask} :
                       (rdAddr == ADDR_AUX) ? {30'h0, vccGood, eventKickEnable} :
                       32'h0000_0000;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : rwd_watchdog

/* rwd_pkg.sv */
// package: register map, field layout and timing constants of the supervision timer
package rwd_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses on the register bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_WDCTRL = 8'h00; // watchdog_control
   localparam logic [7:0] ADDR_IRQSTAT = 8'h04; // sticky event status, write one to clear
   localparam logic [7:0] ADDR_IRQMASK = 8'h08; // interrupt mask, same layout as status
   localparam logic [7:0] ADDR_AUX = 8'h0C; // event_pin_kick_enable, vcc good readback
   // ----------------------------------------------------------------
   // watchdog_control field positions
   // ----------------------------------------------------------------
   localparam int BIT_ENABLE = 7; // watchdog_enable
   localparam int BIT_FLAG = 6; // timeout_flag
   localparam int BIT_DELAY = 5; // start_delay_enable
   localparam int BIT_PULSE = 4; // pulse_width_select
   localparam int BIT_PERMSB = 3; // reserved top bit of period_select
   localparam logic [7:0] WDCTRL_RESET = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // status bit positions
   localparam int IRQ_TIMEOUT = 0; // a time-out happened
   localparam int IRQ_VCCLOSS = 1; // supply loss cleared the enable
   // ----------------------------------------------------------------
   // timing: raw crystal tick is 32.768 kHz, made from the 200 MHz clock
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 200000000;
   localparam longint XTAL_HZ = 32768;
   // ticks are made by a phase accumulator so the long-term rate is exact
   localparam int ACC_W = 32;
   localparam logic [31:0] TICK_INC = 32'(XTAL_HZ * 64'd4294967296 / CLK_HZ);
   // start delay in seconds and in crystal ticks
   localparam int DELAY_S = 64;
   localparam int DELAY_TICKS = DELAY_S * 32768;
   // output pulse widths: 122 us is 4 ticks, 125 ms is 4096 ticks
   localparam int PULSE_SHORT_US = 122;
   localparam int PULSE_SHORT_TICKS = 4;
   localparam int PULSE_LONG_MS = 125;
   localparam int PULSE_LONG_TICKS = 4096;
   localparam int CNT_W = 22; // wide enough for 64 s of ticks
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rwd_pkg

/* rwd_watchdog_chk.sv */
// checker: port-level assertions of the supervision timer, bound into the design
`timescale 1ns/10ps
module rwd_watchdog_chk
   import rwd_pkg::*;
#(
   parameter int TICK_DIV_INC = TICK_INC, // phase step per clock
   parameter int DELAY_LEN = DELAY_TICKS // start delay in ticks
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // pins
   input wire logic vccPresent,
   input wire logic fastEventInput,
   input wire logic timeoutOutputPin,
   input wire logic irq
);
   // ----------------------------------------
   // register copies, updated when a write response appears
   // ----------------------------------------
   localparam int CPT = int'(64'h1_0000_0000 / 64'(TICK_DIV_INC)); // clocks per tick
   localparam int PER[8] = '{32, 512, 2048, 4096, 32768, 524288, 1048576, 2097152};
   logic [7:0] awA, wD, ctrl, mask, aux; // written address, data and register copies
   logic bvPrev, evPrev, pinPrev; // last values, for edge detection
   int startCnt; // clocks since the count was last restarted
   int highCnt; // clocks the pin has stayed high
   int expT; // start-to-pulse clocks
   int expW; // pulse width in clocks
   assign expT = ((ctrl[BIT_DELAY] ? DELAY_LEN : 0) + PER[ctrl[2:0]]) * CPT;
   assign expW = (ctrl[BIT_PULSE] ? PULSE_LONG_TICKS : PULSE_SHORT_TICKS) * CPT;
   // hardware flag set and supply-loss clear come last, so they win over a write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {awA, wD, ctrl, mask, aux} <= '0;
         {bvPrev, evPrev, pinPrev} <= '0;
         startCnt <= 0;
         highCnt <= 0;
      end else begin
         {bvPrev, evPrev, pinPrev} <= {s_axi_bvalid, fastEventInput, timeoutOutputPin};
         startCnt <= startCnt + 1;
         highCnt <= timeoutOutputPin ? highCnt + 1 : 0;
         if (s_axi_awready) awA <= s_axi_awaddr;
         if (s_axi_wready) wD <= s_axi_wdata[7:0];
         // kicks during the start delay are not modelled, so benches avoid them
         if (aux[0] && fastEventInput != evPrev) startCnt <= 0;
         if (s_axi_bvalid && !bvPrev && s_axi_bresp == RESP_OKAY) begin
            if (awA[3:2] == 2'h0) begin
               ctrl <= wD;
               startCnt <= 0;
            end
            if (awA[3:2] == 2'h2) mask <= wD;
            if (awA[3:2] == 2'h3) aux <= wD;
         end
         if (timeoutOutputPin && !pinPrev) ctrl[BIT_FLAG] <= 1'h1;
         if (!vccPresent) ctrl[BIT_ENABLE] <= 1'h0;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking dcb @(posedge clk); endclocking
   default disable iff (reset);
   sequence pulseStart;
      $rose(timeoutOutputPin);
   endsequence
   sequence pulseEnd;
      $fell(timeoutOutputPin);
   endsequence
   pulse_when_armed_a: assert property (
      pulseStart |-> ctrl[BIT_ENABLE] && !ctrl[BIT_FLAG]) else $error("pulse while not armed");
   period_length_a: assert property (
      pulseStart |-> startCnt >= expT - CPT - 2 && startCnt <= expT + 2 * CPT + 6)
      else $error("time-out period wrong");
   pulse_width_a: assert property (
      pulseEnd |-> highCnt >= expW - 2 && highCnt <= expW + 2) else $error("pulse width wrong");
   pulse_gap_a: assert property (
      pulseEnd |-> (!timeoutOutputPin) [*8]) else $error("pulse restarted without flag clear");
   timeout_irq_a: assert property (
      pulseStart ##0 mask[IRQ_TIMEOUT] |-> ##[1:4] irq) else $error("no time-out interrupt");
   supply_irq_a: assert property (
      $fell(vccPresent) && ctrl[BIT_ENABLE] && mask[IRQ_VCCLOSS] |-> ##[2:12] irq)
      else $error("no supply-loss interrupt");
   irq_quiet_a: assert property (
      mask[1:0] == 2'h0 && $past(mask[1:0]) == 2'h0 |-> !irq) else $error("masked interrupt");
   resp_release_a: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
endmodule : rwd_watchdog_chk

bind rwd_watchdog rwd_watchdog_chk #(.TICK_DIV_INC(TICK_DIV_INC), .DELAY_LEN(DELAY_LEN))
   i_chk (.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .vccPresent(vccPresent), .fastEventInput(fastEventInput),
   .timeoutOutputPin(timeoutOutputPin), .irq(irq));

/* rwd_host_model.sv */
// partner: supervised host that counts reset pulses and kicks the event pin
`timescale 1ns/10ps
module rwd_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // supervision pins
   input wire logic timeoutOutputPin,
   input wire logic kick,
   output logic fastEventInput,
   // observation
   output int resetCount
);
   logic pinPrev; // pin level at the last edge
   // a rising pin means the host was sent into reset; a kick inverts the event pin
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinPrev <= 1'h0;
         resetCount <= 0;
         fastEventInput <= 1'h0;
      end else begin
         pinPrev <= timeoutOutputPin;
         if (timeoutOutputPin && !pinPrev) resetCount <= resetCount + 1;
         if (kick) fastEventInput <= !fastEventInput;
      end
   end
endmodule : rwd_host_model

/* test_rwd_watchdog.sv */
// testbench: registers, periods, delay, pulse width, kicks, supply loss, interrupts
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", n, e, a); end end
module test_rwd_watchdog
   import rwd_pkg::*;
;
   logic clk, reset, awvalid, wvalid, bready, arvalid, vccPresent, kick;
   logic awready, wready, bvalid, arready, rvalid, pin, irq, ev;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   int fail_count, compares, hostResets;
   // tick every 4 clocks and an 8-tick start delay keep the run short
   rwd_watchdog #(.TICK_DIV_INC(32'h4000_0000), .DELAY_LEN(8)) i_dut (.clk(clk),
      .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
      .vccPresent(vccPresent), .fastEventInput(ev), .timeoutOutputPin(pin), .irq(irq));
   rwd_host_model i_host (.clk(clk), .reset(reset), .timeoutOutputPin(pin), .kick(kick),
      .fastEventInput(ev), .resetCount(hostResets));
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   // clocks from a control write to the pulse
   function automatic int expClk(input logic [7:0] c);
      int per[8] = '{32, 512, 2048, 4096, 32768, 524288, 1048576, 2097152};
      return ((c[BIT_DELAY] ? 8 : 0) + per[c[2:0]]) * 4;
   endfunction : expClk
   // address and data go together; bready stands until the response is sampled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, dd;
      {ad, dd} = 2'h0;
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      while (!(ad && dd)) begin
         @(posedge clk);
         if (!ad && awready) begin
            ad = 1'h1;
            awvalid <= 1'h0;
         end
         if (!dd && wready) begin
            dd = 1'h1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'h1);
      `CHK("bresp", er, bresp)
      bready <= 1'h0;
      @(posedge clk);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
      input string n);
      {araddr, arvalid} <= {a, 1'h1};
      do @(posedge clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge clk); while (rvalid !== 1'h1);
      `CHK(n, e, rdata)
      `CHK("rresp", er, rresp)
   endtask : rc
   task automatic waitPin(output int n);
      n = 0;
      while (pin !== 1'h1) begin
         @(posedge clk);
         n++;
      end
   endtask : waitPin
   task automatic finish_test();
      if (fail_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      int n;
      logic [7:0] c;
      {reset, awvalid, wvalid, bready, arvalid, kick, vccPresent} = 7'h41;
      {awaddr, araddr, wdata} = '0;
      {fail_count, compares} = 0;
      n = $urandom(32'hD5AA);
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      repeat (8) @(posedge clk);
      rc(ADDR_WDCTRL, 32'h0, RESP_OKAY, "ctrl reset");
      rc(8'h10, 32'h0, RESP_SLVERR, "unmapped");
      wr(8'h10, 32'hFF, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom) & 8'h37;
         wr(ADDR_WDCTRL, {24'h0, c}, RESP_OKAY);
         rc(ADDR_WDCTRL, {24'h0, c}, RESP_OKAY, "ctrl rw");
      end
      // periods 0..3, the second one masked
      for (int s = 0; s < 4; s++) begin
         c = 8'h80 | 8'(s);
         wr(ADDR_IRQMASK, (s == 1) ? 32'h0 : 32'h1, RESP_OKAY);
         wr(ADDR_WDCTRL, {24'h0, c}, RESP_OKAY);
         waitPin(n);
         `CHK("period", 1'h1, n >= expClk(c) - 8 && n <= expClk(c) + 8)
         repeat (3) @(posedge clk);
         `CHK("irq", (s == 1) ? 1'h0 : 1'h1, irq)
         while (pin === 1'h1) @(posedge clk);
         rc(ADDR_WDCTRL, {24'h0, c | 8'h40}, RESP_OKAY, "flag");
         rc(ADDR_IRQSTAT, 32'h1, RESP_OKAY, "status");
         wr(ADDR_IRQSTAT, 32'h1, RESP_OKAY);
         if (s == 0) repeat (300) @(posedge clk);
         `CHK("irq clear", 1'h0, irq)
         `CHK("resets", s + 1, hostResets)
         wr(ADDR_WDCTRL, 32'h0, RESP_OKAY);
      end
      // start delay set before enable, long pulse
      wr(ADDR_WDCTRL, 32'h30, RESP_OKAY);
      wr(ADDR_WDCTRL, 32'hB0, RESP_OKAY);
      waitPin(n);
      `CHK("delay", 1'h1, n >= expClk(8'hB0) - 8 && n <= expClk(8'hB0) + 8)
      n = 0;
      while (pin === 1'h1) begin
         @(posedge clk);
         n++;
      end
      `CHK("width", 1'h1, n >= 16380 && n <= 16388)
      wr(ADDR_WDCTRL, 32'h0, RESP_OKAY);
      // event-pin kicks hold the time-out off
      wr(ADDR_AUX, 32'h1, RESP_OKAY);
      wr(ADDR_WDCTRL, 32'h80, RESP_OKAY);
      for (int k = 0; k < 6; k++) begin
         repeat (40 + $urandom % 40) @(posedge clk);
         kick <= 1'h1;
         @(posedge clk);
         kick <= 1'h0;
      end
      `CHK("kicked", 5, hostResets)
      waitPin(n);
      `CHK("kick period", 1'h1, n >= expClk(8'h80) && n <= expClk(8'h80) + 8)
      {kick, vccPresent} <= 2'h1;
      wr(ADDR_WDCTRL, 32'h0, RESP_OKAY);
      // supply loss while counting a long period
      wr(ADDR_IRQSTAT, 32'h3, RESP_OKAY);
      wr(ADDR_IRQMASK, 32'h2, RESP_OKAY);
      wr(ADDR_WDCTRL, 32'h81, RESP_OKAY);
      repeat (100) @(posedge clk);
      vccPresent <= 1'h0;
      repeat (20) @(posedge clk);
      `CHK("supply irq", 1'h1, irq)
      vccPresent <= 1'h1;
      repeat (2200) @(posedge clk);
      rc(ADDR_WDCTRL, 32'h1, RESP_OKAY, "enable cleared");
      `CHK("no pulse", 6, hostResets)
      finish_test();
   end
   initial begin
      #400000;
      fail_count++;
      finish_test();
   end
endmodule : test_rwd_watchdog
